// ==== event_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "stats_counter_consts.svh"

module event_counter #(
    parameter int WIDTH = `DROP_WIDTH
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // control
    input wire logic inc_in,
    input wire logic clr_in,
    // value
    output logic [WIDTH-1:0] count_out
);

    logic [WIDTH-1:0] count_next;

    // a clear keeps an event of the same cycle; plain add wraps, no overflow flag
    assign count_next = clr_in ? {{(WIDTH-1){1'b0}}, inc_in} : count_out + {{(WIDTH-1){1'b0}}, inc_in};

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else begin
            count_out <= count_next;
        end
    end

endmodule : event_counter

`default_nettype wire

// ==== stats_counter_consts.svh ====
`ifndef STATS_COUNTER_CONSTS_SVH
`define STATS_COUNTER_CONSTS_SVH

// register offsets on the management port
`define REG_TABLE_SELECT 8'h6e
`define REG_INDEX_TRIGGER 8'h6f
`define REG_DATA_BYTE3 8'h75
`define REG_DATA_BYTE2 8'h76
`define REG_DATA_BYTE1 8'h77
`define REG_DATA_BYTE0 8'h78

// table select codes
`define SEL_PER_PORT_READ 8'h1c
`define SEL_DROP_READ 8'h1d

// per-port layout
`define NUM_PORTS 3
`define PORT_STRIDE 32
`define CNT_PER_PORT 5
`define IDX_WAIT_BUSY 8'h1b
`define IDX_COLLISION 8'h1c
`define IDX_ABANDONED 8'h1d
`define IDX_ONE_RETRY 8'h1e
`define IDX_MANY_RETRY 8'h1f

// dropped-packet layout: low index byte of 0x100..0x105
`define DROP_IDX_BASE 8'h00
`define NUM_DROP 6

// word format
`define PER_PORT_WIDTH 30
`define DROP_WIDTH 16
`define VALID_BIT 30
`define RESV_BIT 31
`define DROP_RESV_MSB 30
`define DROP_RESV_LSB 16

`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000

`endif

// ==== stats_counter_indirect_read.sv ====
// Functional notes
// - index 0x1B counts deferred first attempts
// - index 0x1C counts collisions, half duplex only
// - index 0x1D counts frames abandoned, excessive collisions
// - index 0x1E counts success after one collision
// - index 0x1F counts success after several collisions
// - dropped count bits 15-0, reserved above, reset zero
// - 0x100-0x102 hold transmit drops ports 1-3
// - 0x103-0x105 hold receive drops ports 1-3
// - bit 30 low means reread from first byte
// - counters wrap silently, no overflow indication
// - dropped counters carry no valid flag
// - per-port counter clears when read
// - dropped counter keeps value when read
// - per-port word: bit31 zero, bit30 valid, count
// - per-port bases 0x00, 0x20, 0x40, 32 entries
`timescale 1ns/1ps
`default_nettype none
`include "stats_counter_consts.svh"

module stats_counter_indirect_read #(
    parameter int NUM_PORTS = `NUM_PORTS,
    parameter int PORT_CNT_WIDTH = `PER_PORT_WIDTH,
    parameter int DROP_CNT_WIDTH = `DROP_WIDTH
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rdata_valid_out,
    // per-port transmit events, one-cycle pulses, plus the half-duplex level
    input wire logic [NUM_PORTS-1:0] tx_wait_on_busy_medium_in,
    input wire logic [NUM_PORTS-1:0] tx_collision_in,
    input wire logic [NUM_PORTS-1:0] half_duplex_in,
    input wire logic [NUM_PORTS-1:0] tx_abandoned_frame_in,
    input wire logic [NUM_PORTS-1:0] tx_one_retry_success_in,
    input wire logic [NUM_PORTS-1:0] tx_many_retry_success_in,
    // resource drop events, one-cycle pulses
    input wire logic [NUM_PORTS-1:0] tx_discard_in,
    input wire logic [NUM_PORTS-1:0] rx_discard_in
);

    localparam int NUM_PORT_CNT = NUM_PORTS * `CNT_PER_PORT;
    localparam int NUM_DROP_CNT = 2 * NUM_PORTS;

    stats_counter_pkg::access_state_type state_reg;
    stats_counter_pkg::access_state_type state_next;

    logic [7:0] select_reg;
    logic [7:0] index_reg;
    logic [31:0] data_reg;
    logic [31:0] data_next;

    logic [PORT_CNT_WIDTH-1:0] port_count [NUM_PORT_CNT];
    logic [NUM_PORT_CNT-1:0] port_inc;
    logic [NUM_PORT_CNT-1:0] port_hit;
    logic [NUM_PORT_CNT-1:0] port_clr;
    logic [DROP_CNT_WIDTH-1:0] drop_count [NUM_DROP_CNT];
    logic [NUM_DROP_CNT-1:0] drop_inc;
    logic [NUM_DROP_CNT-1:0] drop_hit;

    logic [PORT_CNT_WIDTH-1:0] port_sel_word;
    logic [DROP_CNT_WIDTH-1:0] drop_sel_word;
    logic [31:0] cap_word;
    logic [7:0] rd_mux;

    // decode
    wire wr_select = reg_wr_in && (reg_addr_in == `REG_TABLE_SELECT);
    wire wr_trigger = reg_wr_in && (reg_addr_in == `REG_INDEX_TRIGGER);
    wire wr_byte3 = reg_wr_in && (reg_addr_in == `REG_DATA_BYTE3);
    wire wr_byte2 = reg_wr_in && (reg_addr_in == `REG_DATA_BYTE2);
    wire wr_byte1 = reg_wr_in && (reg_addr_in == `REG_DATA_BYTE1);
    wire wr_byte0 = reg_wr_in && (reg_addr_in == `REG_DATA_BYTE0);
    wire capturing = (state_reg == stats_counter_pkg::ST_CAPTURE);
    // select is sampled in the capture cycle; host sets it before the trigger
    wire sel_per_port = (select_reg == `SEL_PER_PORT_READ);
    wire sel_drop = (select_reg == `SEL_DROP_READ);

    // per-port counters, index = port base + offset
    genvar p;
    genvar k;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            assign port_inc[p*`CNT_PER_PORT+0] = tx_wait_on_busy_medium_in[p];
            assign port_inc[p*`CNT_PER_PORT+1] = tx_collision_in[p] && half_duplex_in[p];
            assign port_inc[p*`CNT_PER_PORT+2] = tx_abandoned_frame_in[p];
            assign port_inc[p*`CNT_PER_PORT+3] = tx_one_retry_success_in[p];
            assign port_inc[p*`CNT_PER_PORT+4] = tx_many_retry_success_in[p];
            for (k = 0; k < `CNT_PER_PORT; k++) begin : g_cnt
                localparam logic [7:0] HIT_IDX = 8'(p * `PORT_STRIDE + int'(`IDX_WAIT_BUSY) + k);
                assign port_hit[p*`CNT_PER_PORT+k] = sel_per_port && (index_reg == HIT_IDX);
                assign port_clr[p*`CNT_PER_PORT+k] = capturing && port_hit[p*`CNT_PER_PORT+k];
                event_counter #(
                    .WIDTH(PORT_CNT_WIDTH)
                ) u_port_cnt (
                    .clk_sys_in(clk_sys_in),
                    .rst_in(rst_in),
                    .inc_in(port_inc[p*`CNT_PER_PORT+k]),
                    .clr_in(port_clr[p*`CNT_PER_PORT+k]),
                    .count_out(port_count[p*`CNT_PER_PORT+k])
                );
            end
        end
    endgenerate

    // dropped counters: transmit ports first, then receive ports
    genvar j;
    generate
        for (j = 0; j < NUM_DROP_CNT; j++) begin : g_drop
            localparam logic [7:0] DROP_IDX = 8'(int'(`DROP_IDX_BASE) + j);
            if (j < NUM_PORTS) begin : g_tx
                assign drop_inc[j] = tx_discard_in[j];
            end else begin : g_rx
                assign drop_inc[j] = rx_discard_in[j-NUM_PORTS];
            end
            assign drop_hit[j] = sel_drop && (index_reg == DROP_IDX);
            // reads never clear these, so they keep accumulating
            event_counter #(
                .WIDTH(DROP_CNT_WIDTH)
            ) u_drop_cnt (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .inc_in(drop_inc[j]),
                .clr_in(1'b0),
                .count_out(drop_count[j])
            );
        end
    endgenerate

    // one-hot hit vectors, so an or-reduction is the selection
    always_comb begin
        port_sel_word = '0;
        drop_sel_word = '0;
        for (int i = 0; i < NUM_PORT_CNT; i++) begin
            port_sel_word = port_sel_word | (port_hit[i] ? port_count[i] : '0);
        end
        for (int i = 0; i < NUM_DROP_CNT; i++) begin
            drop_sel_word = drop_sel_word | (drop_hit[i] ? drop_count[i] : '0);
        end
    end

    // per-port indices outside the implemented set read as a valid zero so the host never spins
    assign cap_word = sel_per_port ? {1'b0, 1'b1, port_sel_word} :
                      sel_drop ? {{(32-DROP_CNT_WIDTH){1'b0}}, drop_sel_word} :
                      `RESET_WORD;

    assign state_next = wr_trigger ? stats_counter_pkg::ST_CAPTURE : stats_counter_pkg::ST_IDLE;

    // trigger drops the valid flag for one cycle; capture wins over host data writes
    assign data_next = capturing ? cap_word :
                       wr_trigger ? `RESET_WORD :
                       {wr_byte3 ? reg_wdata_in : data_reg[31:24],
                        wr_byte2 ? reg_wdata_in : data_reg[23:16],
                        wr_byte1 ? reg_wdata_in : data_reg[15:8],
                        wr_byte0 ? reg_wdata_in : data_reg[7:0]};

    assign rd_mux = (reg_addr_in == `REG_TABLE_SELECT) ? select_reg :
                    (reg_addr_in == `REG_INDEX_TRIGGER) ? index_reg :
                    (reg_addr_in == `REG_DATA_BYTE3) ? data_reg[31:24] :
                    (reg_addr_in == `REG_DATA_BYTE2) ? data_reg[23:16] :
                    (reg_addr_in == `REG_DATA_BYTE1) ? data_reg[15:8] :
                    (reg_addr_in == `REG_DATA_BYTE0) ? data_reg[7:0] :
                    `RESET_BYTE;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= stats_counter_pkg::ST_IDLE;
            data_reg <= `RESET_WORD;
        end else begin
            state_reg <= state_next;
            data_reg <= data_next;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            select_reg <= `RESET_BYTE;
            index_reg <= `RESET_BYTE;
        end else begin
            if (wr_select) begin
                select_reg <= reg_wdata_in;
            end
            if (wr_trigger) begin
                index_reg <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= `RESET_BYTE;
            reg_rdata_valid_out <= 1'b0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : `RESET_BYTE;
            reg_rdata_valid_out <= reg_rd_in;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_wait_busy_count;
        tx_wait_on_busy_medium_in[0] && !port_clr[0] |=> port_count[0] == $past(port_count[0]) + 1'b1;
    endproperty
    a_wait_busy_count: assert property (p_wait_busy_count) else $error("deferral count missed");

    property p_collision_half_duplex;
        !port_inc[1] && !port_clr[1] |=> $stable(port_count[1]);
    endproperty
    a_collision_half_duplex: assert property (p_collision_half_duplex) else $error("collision counted wrongly");

    property p_collision_full_duplex;
        tx_collision_in[0] && !half_duplex_in[0] && !port_clr[1] |=> $stable(port_count[1]);
    endproperty
    a_collision_full_duplex: assert property (p_collision_full_duplex) else $error("full duplex collision counted");

    property p_abandoned_count;
        tx_abandoned_frame_in[1] && !port_clr[7] |=> port_count[7] == $past(port_count[7]) + 1'b1;
    endproperty
    a_abandoned_count: assert property (p_abandoned_count) else $error("abandoned count missed");

    property p_one_retry_count;
        tx_one_retry_success_in[2] && !port_clr[13] |=> port_count[13] == $past(port_count[13]) + 1'b1;
    endproperty
    a_one_retry_count: assert property (p_one_retry_count) else $error("single retry count missed");

    property p_many_retry_count;
        tx_many_retry_success_in[0] && !port_clr[4] |=> port_count[4] == $past(port_count[4]) + 1'b1;
    endproperty
    a_many_retry_count: assert property (p_many_retry_count) else $error("multi retry count missed");

    property p_drop_format;
        capturing && sel_drop |=> data_reg[`DROP_RESV_MSB:`DROP_RESV_LSB] == '0 && !data_reg[`VALID_BIT];
    endproperty
    a_drop_format: assert property (p_drop_format) else $error("dropped word upper bits set");

    property p_tx_drop_map;
        tx_discard_in[1] |=> drop_count[1] == $past(drop_count[1]) + 1'b1;
    endproperty
    a_tx_drop_map: assert property (p_tx_drop_map) else $error("transmit drop not counted");

    property p_rx_drop_map;
        rx_discard_in[0] |=> drop_count[3] == $past(drop_count[3]) + 1'b1;
    endproperty
    a_rx_drop_map: assert property (p_rx_drop_map) else $error("receive drop not counted");

    sequence s_trigger_per_port;
        wr_trigger && sel_per_port && !wr_select;
    endsequence
    sequence s_invalid_then_valid;
        ##1 !data_reg[`VALID_BIT] ##1 data_reg[`VALID_BIT];
    endsequence
    property p_valid_flag;
        s_trigger_per_port |-> s_invalid_then_valid;
    endproperty
    a_valid_flag: assert property (p_valid_flag) else $error("valid flag sequence wrong");

    property p_wrap;
        port_inc[0] && !port_clr[0] && (&port_count[0]) |=> port_count[0] == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_clear_on_read;
        port_clr[5] |=> port_count[5] == {{(PORT_CNT_WIDTH-1){1'b0}}, $past(port_inc[5])};
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("read did not clear");

    property p_capture_value;
        port_clr[5] |=> data_reg[PORT_CNT_WIDTH-1:0] == $past(port_count[5]);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("captured value wrong");

    property p_drop_keep;
        capturing && drop_hit[0] && !drop_inc[0] |=> $stable(drop_count[0]);
    endproperty
    a_drop_keep: assert property (p_drop_keep) else $error("dropped counter changed on read");

    property p_word_format;
        capturing && sel_per_port |=> !data_reg[`RESV_BIT] && data_reg[`VALID_BIT];
    endproperty
    a_word_format: assert property (p_word_format) else $error("per-port word format wrong");

    property p_port_base;
        capturing && sel_per_port && index_reg == 8'h5b |-> port_clr[10];
    endproperty
    a_port_base: assert property (p_port_base) else $error("port 3 base decode wrong");

    property p_port2_base;
        capturing && sel_per_port && index_reg == 8'h3b |-> port_clr[5];
    endproperty
    a_port2_base: assert property (p_port2_base) else $error("port 2 base decode wrong");

    property p_drop_wrap;
        drop_inc[0] && (&drop_count[0]) |=> drop_count[0] == '0;
    endproperty
    a_drop_wrap: assert property (p_drop_wrap) else $error("dropped counter did not wrap");

    property p_tx_drop_port3;
        tx_discard_in[2] |=> drop_count[2] == $past(drop_count[2]) + 1'b1;
    endproperty
    a_tx_drop_port3: assert property (p_tx_drop_port3) else $error("port 3 transmit drop not counted");

    property p_rx_drop_port3;
        rx_discard_in[2] |=> drop_count[5] == $past(drop_count[5]) + 1'b1;
    endproperty
    a_rx_drop_port3: assert property (p_rx_drop_port3) else $error("port 3 receive drop not counted");

    property p_byte3_valid;
        reg_rd_in && (reg_addr_in == `REG_DATA_BYTE3) |=> reg_rdata_valid_out && reg_rdata_out == $past(data_reg[31:24]);
    endproperty
    a_byte3_valid: assert property (p_byte3_valid) else $error("top data byte or valid flag wrong");

    property p_many_retry_port2;
        tx_many_retry_success_in[1] && !port_clr[9] |=> port_count[9] == $past(port_count[9]) + 1'b1;
    endproperty
    a_many_retry_port2: assert property (p_many_retry_port2) else $error("port 2 multi retry missed");

    property p_wait_busy_port3;
        tx_wait_on_busy_medium_in[2] && !port_clr[10] |=> port_count[10] == $past(port_count[10]) + 1'b1;
    endproperty
    a_wait_busy_port3: assert property (p_wait_busy_port3) else $error("port 3 deferral missed");

    property p_one_retry_port1;
        tx_one_retry_success_in[0] && !port_clr[3] |=> port_count[3] == $past(port_count[3]) + 1'b1;
    endproperty
    a_one_retry_port1: assert property (p_one_retry_port1) else $error("port 1 single retry missed");

    property p_drop_capture;
        capturing && drop_hit[3] |=> data_reg[DROP_CNT_WIDTH-1:0] == $past(drop_count[3]);
    endproperty
    a_drop_capture: assert property (p_drop_capture) else $error("dropped value captured wrong");

endmodule : stats_counter_indirect_read

`default_nettype wire

// ==== stats_counter_indirect_read_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "stats_counter_consts.svh"

module stats_counter_indirect_read_tb;
    logic clk_sys_in;
    logic rst_in;
    logic [2:0] half_duplex;
    logic [2:0] ev [0:6];
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rdata_valid;
    logic timed_out;
    int fail_count;
    int checked;
    int held;

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    stats_counter_indirect_read stats_counter_indirect_read_i (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd),
        .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata),
        .reg_rdata_valid_out(reg_rdata_valid),
        .tx_wait_on_busy_medium_in(ev[0]),
        .tx_collision_in(ev[1]),
        .half_duplex_in(half_duplex),
        .tx_abandoned_frame_in(ev[2]),
        .tx_one_retry_success_in(ev[3]),
        .tx_many_retry_success_in(ev[4]),
        .tx_discard_in(ev[5]),
        .rx_discard_in(ev[6])
    );

    stats_host_model stats_host_model_i (
        .clk_sys_in(clk_sys_in),
        .reg_addr_out(reg_addr),
        .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd),
        .reg_wdata_out(reg_wdata),
        .reg_rdata_in(reg_rdata),
        .reg_rdata_valid_in(reg_rdata_valid),
        .timed_out_out(timed_out)
    );

    // counts the edges on which the port 3 deferral event is high
    always @(posedge clk_sys_in) begin
        if (ev[0][2] === 1'b1) begin
            held++;
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    always @(posedge timed_out) begin
        fail_count++;
        $display("CHECK FAILED read answer expected 1 seen 0");
        complete_run();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // holds one event input high for n consecutive rising edges
    task automatic pulse(input int k, input int p, input int n);
        @(negedge clk_sys_in);
        ev[k][p] = 1'b1;
        repeat (n) @(negedge clk_sys_in);
        ev[k][p] = 1'b0;
    endtask : pulse

    initial begin
        logic [7:0] b;
        logic [7:0] idx;
        logic [31:0] w;
        logic [31:0] w2;
        fail_count = 0;
        checked = 0;
        held = 0;
        rst_in = 1'b1;
        half_duplex = 3'h7;
        for (int k = 0; k < 7; k++) begin
            ev[k] = 3'h0;
        end
        repeat (8) @(negedge clk_sys_in);
        rst_in = 1'b0;
        stats_host_model_i.read_reg(8'h70, b);
        check("unmapped offset", {24'h00_0000, b}, 32'h0000_0000);
        stats_host_model_i.read_counter(`SEL_PER_PORT_READ, `IDX_WAIT_BUSY, w);
        check("per-port after reset", w, 32'h4000_0000);
        stats_host_model_i.read_counter(`SEL_DROP_READ, 8'h00, w);
        check("drop after reset", w, 32'h0000_0000);
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 5; k++) begin
                pulse(k, p, 1 + k + 5 * p);
            end
        end
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 5; k++) begin
                idx = 8'(p * `PORT_STRIDE) + `IDX_WAIT_BUSY + 8'(k);
                stats_host_model_i.read_counter(`SEL_PER_PORT_READ, idx, w);
                check("per-port count", w, 32'h4000_0000 | 32'(1 + k + 5 * p));
                stats_host_model_i.read_counter(`SEL_PER_PORT_READ, idx, w);
                check("per-port reread", w, 32'h4000_0000);
            end
        end
        half_duplex[0] = 1'b0;
        pulse(1, 0, 3);
        stats_host_model_i.read_counter(`SEL_PER_PORT_READ, `IDX_COLLISION, w);
        check("full duplex collisions", w, 32'h4000_0000);
        half_duplex[0] = 1'b1;
        for (int j = 0; j < 6; j++) begin
            pulse(5 + j / 3, j % 3, j + 2);
            stats_host_model_i.read_counter(`SEL_DROP_READ, 8'(j), w);
            check("drop count", w, 32'(j + 2));
            stats_host_model_i.read_counter(`SEL_DROP_READ, 8'(j), w);
            check("drop reread", w, 32'(j + 2));
        end
        // 65535 more on a count of 2 must wrap to 1 with no flag
        pulse(5, 0, 65535);
        stats_host_model_i.read_counter(`SEL_DROP_READ, 8'h00, w);
        check("drop wrap", w, 32'h0000_0001);
        stats_host_model_i.write_reg(`REG_DATA_BYTE2, 8'h5a);
        stats_host_model_i.read_reg(`REG_DATA_BYTE2, b);
        check("data byte write", {24'h00_0000, b}, 32'h0000_005a);
        stats_host_model_i.read_reg(`REG_TABLE_SELECT, b);
        check("select readback", {24'h00_0000, b}, 32'h0000_001d);
        held = 0;
        @(negedge clk_sys_in);
        ev[0][2] = 1'b1;
        stats_host_model_i.read_counter(`SEL_PER_PORT_READ, 8'h5b, w);
        ev[0][2] = 1'b0;
        stats_host_model_i.read_counter(`SEL_PER_PORT_READ, 8'h5b, w2);
        check("events across clear", {2'b00, w[29:0]} + {2'b00, w2[29:0]}, 32'(held));
        complete_run();
    end
endmodule : stats_counter_indirect_read_tb
`default_nettype wire

// ==== stats_counter_pkg.sv ====
package stats_counter_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_CAPTURE = 2'b10
    } access_state_type;

endpackage : stats_counter_pkg

// ==== stats_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "stats_counter_consts.svh"

module stats_host_model (
    // clock
    input wire logic clk_sys_in,
    // register port
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_wdata_out,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rdata_valid_in,
    // bus watchdog
    output logic timed_out_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 8'h00;
        timed_out_out = 1'b0;
    end

    // strobes last exactly one rising edge, launched and dropped on falling edges
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_in);
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_wr_out = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        // released data must not keep showing the last byte
        reg_wdata_out = ~data;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        int n;
        @(negedge clk_sys_in);
        reg_addr_out = addr;
        reg_rd_out = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_out = 1'b0;
        n = 0;
        while (reg_rdata_valid_in !== 1'b1 && n < 4) begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n == 4) begin
            timed_out_out = 1'b1;
        end
        data = reg_rdata_in;
    endtask : read_reg

    // the bench reads each counter long before it could wrap twice
    task automatic read_counter(input logic [7:0] sel, input logic [7:0] idx, output logic [31:0] word);
        logic [7:0] b;
        int tries;
        word = 32'h0000_0000;
        write_reg(`REG_TABLE_SELECT, sel);
        write_reg(`REG_INDEX_TRIGGER, idx);
        if (sel == `SEL_PER_PORT_READ) begin
            tries = 0;
            do begin
                read_reg(`REG_DATA_BYTE3, b);
                tries++;
            end while (b[6] !== 1'b1 && tries < 4);
            word[31:24] = b;
            read_reg(`REG_DATA_BYTE2, b);
            word[23:16] = b;
        end
        read_reg(`REG_DATA_BYTE1, b);
        word[15:8] = b;
        read_reg(`REG_DATA_BYTE0, b);
        word[7:0] = b;
    endtask : read_counter
endmodule : stats_host_model
`default_nettype wire
